// File: design/pdc_port_driver_control.sv
// port driver control: quasi drivers, port_zero/two bus takeover, serial pins
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pdc_port_driver_control import pdc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PDC_W-1:0] quasi_pin_i,
  input wire logic external_access_pin_n_i,
  input wire logic pc_external_i,
  input wire logic bus_cycle_i,
  input wire logic addr16_i,
  input wire logic [PDC_W-1:0] bus_data_i,
  input wire logic [PDC_W-1:0] bus_addr_hi_i,
  input wire logic slave_select_in_n_i,
  output logic [PDC_W-1:0] weak_pu_o,
  output logic [PDC_W-1:0] medium_pu_o,
  output logic [PDC_W-1:0] strong_pu_o,
  output logic [PDC_W-1:0] pulldown_o,
  output logic [PDC_W-1:0] port_zero_pu_o,
  output logic [PDC_W-1:0] port_zero_pd_o,
  output logic [PDC_W-1:0] port_two_strong_pu_o,
  output logic [PDC_W-1:0] port_two_weak_pu_o,
  output logic [PDC_W-1:0] port_two_pd_o,
  output logic bus_mode_o,
  output logic sclk_pushpull_o,
  output logic sclk_tristate_o,
  output logic tx_pushpull_o,
  output logic tx_tristate_o,
  output logic rx_tristate_o,
  output logic slave_sel_tristate_o,
  output logic port5_bidir_o
);
  // ==========================================================
  // pin synchronisers
  logic [PDC_W-1:0] pin_s1_ff, pin_ff;
  logic acc_s1_ff, acc_ff, ssel_s1_ff, ssel_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_ff <= PDC_ZEROS;
      pin_ff <= PDC_ZEROS;
      acc_s1_ff <= 1'b1;
      acc_ff <= 1'b1;
      ssel_s1_ff <= 1'b1;
      ssel_ff <= 1'b1;
    end else begin
      pin_s1_ff <= quasi_pin_i;
      pin_ff <= pin_s1_ff;
      acc_s1_ff <= external_access_pin_n_i;
      acc_ff <= acc_s1_ff;
      ssel_s1_ff <= slave_select_in_n_i;
      ssel_ff <= ssel_s1_ff;
    end
  end

  // ==========================================================
  // axi4-lite slave; one write and one read outstanding
  logic aw_hold_ff, w_hold_ff, bvalid_ff, arready_ff, rvalid_ff, awready_ff, wready_ff, wstrb0_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  wire aw_take = s_axi_awvalid && !aw_hold_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_hold_ff && !bvalid_ff;
  wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire wr_full = wstrb0_ff;
  wire nxt_aw_hold = !wr_go && (aw_take || aw_hold_ff);
  wire nxt_w_hold = !wr_go && (w_take || w_hold_ff);
  wire nxt_bvalid = wr_go || (bvalid_ff && !s_axi_bready);
  wire hit_a = wr_go && wr_full && (awaddr_ff == PDC_ADR_LATCH_A);
  wire hit_z = wr_go && wr_full && (awaddr_ff == PDC_ADR_LATCH_Z);
  wire hit_t = wr_go && wr_full && (awaddr_ff == PDC_ADR_LATCH_T);
  wire hit_c = wr_go && wr_full && (awaddr_ff == PDC_ADR_CTRL);
  wire wr_map = (awaddr_ff == PDC_ADR_LATCH_A) || (awaddr_ff == PDC_ADR_LATCH_Z) ||
    (awaddr_ff == PDC_ADR_LATCH_T) || (awaddr_ff == PDC_ADR_CTRL) ||
    (awaddr_ff == PDC_ADR_STAT);
  wire [1:0] nxt_bresp = wr_map ? PDC_RESP_OKAY : PDC_RESP_SLVERR;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_ff <= PDC_RESP_OKAY;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      wstrb0_ff <= 1'b0;
    end else begin
      awready_ff <= !nxt_aw_hold && !nxt_bvalid;
      wready_ff <= !nxt_w_hold && !nxt_bvalid;
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ==========================================================
  // latches and control
  logic [PDC_W-1:0] latch_a_ff, latch_z_ff, latch_t_ff;
  logic [PDC_C_W-1:0] ctrl_ff;
  logic bus_ff;
  wire [PDC_W-1:0] wbyte = wdata_ff[PDC_W-1:0];
  wire nxt_bus = !acc_ff || pc_external_i;
  // bus mode: port_zero latch is refilled with ones, port_two kept
  wire [PDC_W-1:0] nxt_latch_z = bus_ff ? PDC_ONES : (hit_z ? wbyte : latch_z_ff);
  wire [PDC_W-1:0] nxt_latch_t = hit_t ? wbyte : latch_t_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_a_ff <= PDC_ONES;
      latch_z_ff <= PDC_ONES;
      latch_t_ff <= PDC_ONES;
      ctrl_ff <= PDC_CTRL_RST;
      bus_ff <= 1'b0;
    end else begin
      if (hit_a)
        latch_a_ff <= wbyte;
      latch_z_ff <= nxt_latch_z;
      latch_t_ff <= nxt_latch_t;
      if (hit_c)
        ctrl_ff <= wdata_ff[PDC_C_W-1:0];
      bus_ff <= nxt_bus;
    end
  end

  // ==========================================================
  // read path
  wire [31:0] stat_word = {23'h000000, bus_ff, pin_ff};
  wire [31:0] rd_mux =
    (s_axi_araddr == PDC_ADR_LATCH_A) ? {24'h000000, latch_a_ff} :
    (s_axi_araddr == PDC_ADR_LATCH_Z) ? {24'h000000, latch_z_ff} :
    (s_axi_araddr == PDC_ADR_LATCH_T) ? {24'h000000, latch_t_ff} :
    (s_axi_araddr == PDC_ADR_CTRL) ? {28'h0000000, ctrl_ff} :
    (s_axi_araddr == PDC_ADR_STAT) ? stat_word : 32'h0000_0000;
  wire rd_map = (s_axi_araddr == PDC_ADR_LATCH_A) || (s_axi_araddr == PDC_ADR_LATCH_Z) ||
    (s_axi_araddr == PDC_ADR_LATCH_T) || (s_axi_araddr == PDC_ADR_CTRL) ||
    (s_axi_araddr == PDC_ADR_STAT);
  wire ar_take = s_axi_arvalid && arready_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= PDC_RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_map ? PDC_RESP_OKAY : PDC_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ==========================================================
  // quasi-bidirectional pin drivers, one per bit
  pdc_drv_t drv_st [PDC_W];
  logic [PDC_W-1:0] prev_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      prev_ff <= PDC_ONES;
    else
      prev_ff <= latch_a_ff;
  end
  genvar gi;
  generate
    for (gi = 0; gi < PDC_W; gi++) begin : g_quasi
      logic [1:0] cnt_ff;
      // only a real zero-to-one edge starts the pulse; one over one does not
      wire rise = latch_a_ff[gi] && !prev_ff[gi];
      wire [1:0] nxt_cnt = rise ? PDC_FORCE_LD :
        ((cnt_ff != PDC_CNT_ZERO) ? cnt_ff - PDC_CNT_ONE : PDC_CNT_ZERO);
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
          cnt_ff <= PDC_CNT_ZERO;
        else
          cnt_ff <= nxt_cnt;
      end
      always_comb begin
        if (!latch_a_ff[gi])
          drv_st[gi] = PDC_OUT_LOW;
        else if (nxt_cnt != PDC_CNT_ZERO)
          drv_st[gi] = PDC_FORCED_HIGH;
        else if (pin_ff[gi])
          drv_st[gi] = PDC_IN_HIGH;
        else
          drv_st[gi] = PDC_IN_LOW;
      end
      logic wk_ff, md_ff, st_ff, pd_ff;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          wk_ff <= 1'b1;
          md_ff <= 1'b0;
          st_ff <= 1'b0;
          pd_ff <= 1'b0;
        end else begin
          case (drv_st[gi])
            PDC_IN_LOW: begin
              wk_ff <= 1'b1;
              md_ff <= 1'b0;
              st_ff <= 1'b0;
              pd_ff <= 1'b0;
            end
            PDC_IN_HIGH: begin
              wk_ff <= 1'b1;
              md_ff <= 1'b1;
              st_ff <= 1'b0;
              pd_ff <= 1'b0;
            end
            PDC_FORCED_HIGH: begin
              wk_ff <= 1'b1;
              md_ff <= 1'b1;
              st_ff <= 1'b1;
              pd_ff <= 1'b0;
            end
            default: begin
              wk_ff <= 1'b0;
              md_ff <= 1'b0;
              st_ff <= 1'b0;
              pd_ff <= 1'b1;
            end
          endcase
        end
      end
      assign weak_pu_o[gi] = wk_ff;
      assign medium_pu_o[gi] = md_ff;
      assign strong_pu_o[gi] = st_ff;
      assign pulldown_o[gi] = pd_ff;
    end
  endgenerate

  // ==========================================================
  // port_zero / port_two drivers
  wire [PDC_W-1:0] two_src = bus_ff ? bus_addr_hi_i : latch_t_ff;
  wire two_strong = bus_ff && bus_cycle_i && addr16_i;
  logic [PDC_W-1:0] p0pu_ff, p0pd_ff, p2s_ff, p2w_ff, p2pd_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p0pu_ff <= PDC_ZEROS;
      p0pd_ff <= PDC_ZEROS;
      p2s_ff <= PDC_ZEROS;
      p2w_ff <= PDC_ONES;
      p2pd_ff <= PDC_ZEROS;
    end else begin
      // outside bus cycles port_zero is open drain; a one floats the pin
      p0pu_ff <= (bus_ff && bus_cycle_i) ? bus_data_i : PDC_ZEROS;
      p0pd_ff <= bus_ff ? (bus_cycle_i ? ~bus_data_i : PDC_ZEROS) : ~latch_z_ff;
      p2s_ff <= two_strong ? two_src : PDC_ZEROS;
      p2w_ff <= two_strong ? PDC_ZEROS : two_src;
      p2pd_ff <= ~two_src;
    end
  end
  assign port_zero_pu_o = p0pu_ff;
  assign port_zero_pd_o = p0pd_ff;
  assign port_two_strong_pu_o = p2s_ff;
  assign port_two_weak_pu_o = p2w_ff;
  assign port_two_pd_o = p2pd_ff;
  assign bus_mode_o = bus_ff;

  // ==========================================================
  // serial channel pin control and port five structure
  wire en = ctrl_ff[PDC_C_SSCEN];
  wire mst = ctrl_ff[PDC_C_MASTER];
  wire tx_sel = !ssel_ff && ctrl_ff[PDC_C_TXEN];
  logic scpp_ff, scts_ff, txpp_ff, txts_ff, rxts_ff, slts_ff, p5_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scpp_ff <= 1'b0;
      scts_ff <= 1'b0;
      txpp_ff <= 1'b0;
      txts_ff <= 1'b0;
      rxts_ff <= 1'b0;
      slts_ff <= 1'b0;
      p5_ff <= 1'b0;
    end else begin
      scpp_ff <= en && mst;
      scts_ff <= en && !mst;
      txpp_ff <= en;
      txts_ff <= en && !mst && !tx_sel;
      rxts_ff <= en;
      slts_ff <= en && !mst;
      p5_ff <= ctrl_ff[PDC_C_P5SEL];
    end
  end
  assign sclk_pushpull_o = scpp_ff;
  assign sclk_tristate_o = scts_ff;
  assign tx_pushpull_o = txpp_ff;
  assign tx_tristate_o = txts_ff;
  assign rx_tristate_o = rxts_ff;
  assign slave_sel_tristate_o = slts_ff;
  assign port5_bidir_o = p5_ff;

  // ==========================================================
  // checks
  property p_low_pd;
    @(posedge clk_i) disable iff (rst_i) !latch_a_ff[0] |=> pulldown_o[0] && !weak_pu_o[0];
  endproperty
  a_low_pd: assert property (p_low_pd) else $error("zero latch not pulling down");
  sequence s_rise0;
    !prev_ff[0] && latch_a_ff[0];
  endsequence
  property p_force;
    @(posedge clk_i) disable iff (rst_i)
      s_rise0 ##1 latch_a_ff[0] [*3] |-> ##0 $past(strong_pu_o[0], 2) && $past(strong_pu_o[0]) &&
        !strong_pu_o[0] && !$past(strong_pu_o[0], 3);
  endproperty
  a_force: assert property (p_force) else $error("forced high not two cycles");
  property p_no_force;
    @(posedge clk_i) disable iff (rst_i)
      (latch_a_ff[0] && prev_ff[0] && g_quasi[0].cnt_ff == PDC_CNT_ZERO) |=> !strong_pu_o[0];
  endproperty
  a_no_force: assert property (p_no_force) else $error("pulse on one over one");
  property p_med;
    @(posedge clk_i) disable iff (rst_i)
      (latch_a_ff[1] && g_quasi[1].cnt_ff == PDC_CNT_ZERO && prev_ff[1])
        |=> medium_pu_o[1] == $past(pin_ff[1]);
  endproperty
  a_med: assert property (p_med) else $error("medium pullup not following pin");
  property p_zero_pu;
    @(posedge clk_i) disable iff (rst_i) !bus_ff |=> port_zero_pu_o == PDC_ZEROS;
  endproperty
  a_zero_pu: assert property (p_zero_pu) else $error("port_zero pullup outside bus");
  property p_fill;
    @(posedge clk_i) disable iff (rst_i) bus_ff |=> latch_z_ff == PDC_ONES;
  endproperty
  a_fill: assert property (p_fill) else $error("port_zero latch not filled");
  property p_sclk;
    @(posedge clk_i) disable iff (rst_i)
      en |=> sclk_pushpull_o == $past(mst) && sclk_tristate_o == !$past(mst);
  endproperty
  a_sclk: assert property (p_sclk) else $error("clock pin both drives");
  property p_tx;
    @(posedge clk_i) disable iff (rst_i) (en && mst) |=> tx_pushpull_o && !tx_tristate_o;
  endproperty
  a_tx: assert property (p_tx) else $error("master tx drive wrong");
  property p_rx;
    @(posedge clk_i) disable iff (rst_i) en |=> rx_tristate_o && slts_ff == !$past(mst);
  endproperty
  a_rx: assert property (p_rx) else $error("serial input not hi-z");
endmodule

// File: inc/pdc_pkg.sv
// package: constants and types for the port driver control block
package pdc_pkg;
  // ==========================================================
  // widths
  localparam int PDC_W = 8;
  localparam logic [PDC_W-1:0] PDC_ONES = 8'hff;
  localparam logic [PDC_W-1:0] PDC_ZEROS = 8'h00;
  // ==========================================================
  // timing: forced high lasts two machine cycles
  localparam int PDC_FORCE_CYC = 2;
  localparam logic [1:0] PDC_FORCE_LD = 2'h2;
  localparam logic [1:0] PDC_CNT_ZERO = 2'h0;
  localparam logic [1:0] PDC_CNT_ONE = 2'h1;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] PDC_ADR_LATCH_A = 8'h00; // quasi port latch
  localparam logic [7:0] PDC_ADR_LATCH_Z = 8'h04; // port_zero latch
  localparam logic [7:0] PDC_ADR_LATCH_T = 8'h08; // port_two latch
  localparam logic [7:0] PDC_ADR_CTRL = 8'h0c;    // control bits
  localparam logic [7:0] PDC_ADR_STAT = 8'h10;    // pin levels and bus mode
  // control field positions
  localparam int PDC_C_P5SEL = 0;
  localparam int PDC_C_SSCEN = 1;
  localparam int PDC_C_MASTER = 2;
  localparam int PDC_C_TXEN = 3;
  localparam int PDC_C_W = 4;
  localparam logic [PDC_C_W-1:0] PDC_CTRL_RST = 4'h0;
  localparam logic [1:0] PDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDC_RESP_SLVERR = 2'h2;
  // ==========================================================
  // driver state per quasi pin
  typedef enum logic [1:0] {
    PDC_IN_LOW,
    PDC_IN_HIGH,
    PDC_FORCED_HIGH,
    PDC_OUT_LOW
  } pdc_drv_t;
endpackage

// File: tb/pdc_pin_model.sv
// pin model: external load on the quasi port pins
`timescale 1ns/10ps
module pdc_pin_model (
  input wire logic [7:0] weak_pu_i,
  input wire logic [7:0] medium_pu_i,
  input wire logic [7:0] strong_pu_i,
  input wire logic [7:0] pulldown_i,
  input wire logic [7:0] load_low_i,
  output logic [7:0] pin_o
);
  // ==========================================================
  // pin level
  // a load heavier than the weak pullup holds the pin low;
  // internal pullups mean a released pin is never left floating
  assign pin_o = ~(pulldown_i | load_low_i) & (weak_pu_i | medium_pu_i | strong_pu_i);
endmodule

// File: tb/tb_port_driver_control.sv
// testbench: port driver control block
`timescale 1ns/10ps
module tb_port_driver_control import pdc_pkg::*;;
  logic clk_i, rst_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [PDC_W-1:0] quasi_pin_i, bus_data_i, bus_addr_hi_i, load_low;
  logic external_access_pin_n_i, pc_external_i, bus_cycle_i, addr16_i, slave_select_in_n_i;
  logic [PDC_W-1:0] weak_pu_o, medium_pu_o, strong_pu_o, pulldown_o;
  logic [PDC_W-1:0] port_zero_pu_o, port_zero_pd_o;
  logic [PDC_W-1:0] port_two_strong_pu_o, port_two_weak_pu_o, port_two_pd_o;
  logic bus_mode_o, sclk_pushpull_o, sclk_tristate_o, tx_pushpull_o, tx_tristate_o;
  logic rx_tristate_o, slave_sel_tristate_o, port5_bidir_o;
  logic [6:0] ser;
  int error_cnt, tests_run, cnt;
  // ==========================================================
  // rows: ctrl nibble, slave select level, expected serial controls
  localparam logic [11:0] ROWS [9] = '{12'h080, 12'h6d4, 12'h2be, 12'ha36, 12'habe,
    12'h23e, 12'h181, 12'hd01, 12'he54};
  assign ser = {sclk_pushpull_o, sclk_tristate_o, tx_pushpull_o, tx_tristate_o,
    rx_tristate_o, slave_sel_tristate_o, port5_bidir_o};
  pdc_port_driver_control dut (.clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .quasi_pin_i, .external_access_pin_n_i, .pc_external_i,
    .bus_cycle_i, .addr16_i, .bus_data_i, .bus_addr_hi_i, .slave_select_in_n_i, .weak_pu_o,
    .medium_pu_o, .strong_pu_o, .pulldown_o, .port_zero_pu_o, .port_zero_pd_o,
    .port_two_strong_pu_o, .port_two_weak_pu_o, .port_two_pd_o, .bus_mode_o,
    .sclk_pushpull_o, .sclk_tristate_o, .tx_pushpull_o, .tx_tristate_o, .rx_tristate_o,
    .slave_sel_tristate_o, .port5_bidir_o);
  pdc_pin_model u_pins (.weak_pu_i(weak_pu_o), .medium_pu_i(medium_pu_o),
    .strong_pu_i(strong_pu_o), .pulldown_i(pulldown_o), .load_low_i(load_low),
    .pin_o(quasi_pin_i));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    // no local limit: only the watchdog may end a wait
    while (!(aw && w)) begin
      @(posedge clk_i);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk_i);
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wrap_up;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {pc_external_i, bus_cycle_i, addr16_i, bus_data_i, bus_addr_hi_i} = '0;
    external_access_pin_n_i = 1'b1;
    slave_select_in_n_i = 1'b1;
    load_low = 8'h0f;
    error_cnt = 0;
    tests_run = 0;
    settle(16);
    chk("weak_rst", 8'hff, weak_pu_o);
    chk("drv_rst", 24'h0, {strong_pu_o, pulldown_o, medium_pu_o});
    chk("ser_rst", 7'h00, ser);
    @(posedge clk_i);
    rst_i <= 1'b0;
    settle(6);
    chk("medium_load", 8'hf0, medium_pu_o);
    @(posedge clk_i);
    load_low <= 8'h00;
    settle(6);
    chk("medium_free", 8'hff, medium_pu_o);
    for (int i = 0; i < 9; i++) begin
      axi_wr(PDC_ADR_CTRL, {28'h0, ROWS[i][11:8]}, rs);
      slave_select_in_n_i <= ROWS[i][7];
      settle(5);
      chk("serial", ROWS[i][6:0], ser);
      axi_rd(PDC_ADR_CTRL, rd, rs);
      chk("ctrl", {28'h0, ROWS[i][11:8]}, rd);
    end
    // awkward cases: partial latch, zero-to-one pulse, repeated one
    axi_wr(PDC_ADR_LATCH_A, 32'h0000_00f0, rs);
    settle(6);
    chk("pulldown", 8'h0f, pulldown_o);
    chk("weak", 8'hf0, weak_pu_o);
    chk("medium", 8'hf0, medium_pu_o);
    axi_wr(PDC_ADR_LATCH_A, 32'h0000_00ff, rs);
    cnt = 0;
    repeat (10) begin
      #1 if (strong_pu_o === 8'h0f) cnt++;
      @(posedge clk_i);
    end
    chk("forced_len", 2, cnt);
    settle(2);
    chk("steady", 32'h00ffff00, {strong_pu_o, weak_pu_o, medium_pu_o, pulldown_o});
    axi_wr(PDC_ADR_LATCH_A, 32'h0000_00ff, rs);
    cnt = 0;
    repeat (10) begin
      #1 if (strong_pu_o !== 8'h00) cnt++;
      @(posedge clk_i);
    end
    chk("reforce", 0, cnt);
    // port_zero and port_two, general use then bus takeover
    axi_wr(PDC_ADR_LATCH_Z, 32'h0000_00f0, rs);
    axi_wr(PDC_ADR_LATCH_T, 32'h0000_0012, rs);
    settle(4);
    chk("zero_pd", 8'h0f, port_zero_pd_o);
    chk("zero_pu", 8'h00, port_zero_pu_o);
    chk("two_gen", 24'h0012ed, {port_two_strong_pu_o, port_two_weak_pu_o, port_two_pd_o});
    @(posedge clk_i);
    pc_external_i <= 1'b1;
    bus_cycle_i <= 1'b1;
    addr16_i <= 1'b1;
    bus_data_i <= 8'ha5;
    bus_addr_hi_i <= 8'h3c;
    settle(5);
    chk("bus_mode", 1'b1, bus_mode_o);
    chk("zero_bus", 16'ha55a, {port_zero_pu_o, port_zero_pd_o});
    chk("two_bus", 24'h3c00c3, {port_two_strong_pu_o, port_two_weak_pu_o, port_two_pd_o});
    axi_rd(PDC_ADR_LATCH_Z, rd, rs);
    chk("latch_z", 32'h0000_00ff, rd);
    axi_rd(PDC_ADR_LATCH_T, rd, rs);
    chk("latch_t", 32'h0000_0012, rd);
    axi_rd(PDC_ADR_STAT, rd, rs);
    chk("stat_bus", 1'b1, rd[8]);
    @(posedge clk_i);
    pc_external_i <= 1'b0;
    bus_cycle_i <= 1'b0;
    external_access_pin_n_i <= 1'b0;
    settle(6);
    chk("bus_pin", 1'b1, bus_mode_o);
    @(posedge clk_i);
    external_access_pin_n_i <= 1'b1;
    settle(6);
    chk("bus_off", 1'b0, bus_mode_o);
    chk("zero_after", 8'h00, port_zero_pd_o);
    // unmapped read and read-only write
    axi_rd(8'h20, rd, rs);
    chk("unmapped", {30'h0, PDC_RESP_SLVERR}, {rd[29:0], rs});
    axi_wr(PDC_ADR_STAT, 32'h0000_0000, rs);
    chk("stat_wr", PDC_RESP_OKAY, rs);
    // mid-run reset with a zero latch and an enabled channel
    axi_wr(PDC_ADR_LATCH_A, 32'h0000_0000, rs);
    @(posedge clk_i);
    rst_i <= 1'b1;
    settle(2);
    chk("weak_rst2", 8'hff, weak_pu_o);
    chk("pd_rst2", 8'h00, pulldown_o);
    chk("ser_rst2", 7'h00, ser);
    @(posedge clk_i);
    rst_i <= 1'b0;
    axi_rd(PDC_ADR_LATCH_A, rd, rs);
    chk("latch_rst2", 32'h0000_00ff, rd);
    wrap_up();
  end
endmodule
